// ===== kbc_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module kbc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // ==========================================================
    // handshake
    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign push     = clkEn && inValid && inReady;
    assign pop      = clkEn && outValid && outReady;
    assign outData  = mem[rdPtr_r];

    // storage has no reset; only pointers and count need one
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // pointers wrap at depth
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : kbc_fifo

// ===== kbc_host_mailbox_port.sv
// keyboard-controller host mailbox: host i/o port, cpu port, pins, powerdown
`timescale 1ns/1ps
`include "kbc_mailbox_params.svh"

module kbc_host_mailbox_port
    import kbc_mailbox_pkg::*;
#(
    parameter int HOLD_CYC   = `KBC_HOLD_CYC,
    parameter int FIFO_DEPTH = `KBC_FIFO_DEPTH
) (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  clkEn,
    // host i/o port
    input  wire logic [7:0]            hostAddr,
    input  wire logic                  hostWr,
    input  wire logic                  hostRd,
    input  wire kbc_mailbox_pkg::byte_t hostWrData,
    output kbc_mailbox_pkg::byte_t     hostRdData,
    output logic                       hostWrReady,
    // embedded cpu side
    input  wire logic                  cpuDataWr,
    input  wire kbc_mailbox_pkg::byte_t cpuWrData,
    input  wire logic                  cpuDataRd,
    output kbc_mailbox_pkg::byte_t     cpuRdData,
    output logic                       cpuInValid,
    input  wire logic                  cpuStatusWr,
    input  wire logic                  cpuEnFlags,
    input  wire kbc_mailbox_pkg::byte_t port1Out,
    input  wire kbc_mailbox_pkg::byte_t port2Out,
    input  wire logic                  port1OpenDrain,
    input  wire logic                  cpuHalt,
    input  wire logic                  cpuStop,
    input  wire logic                  ibfIntEnable,
    input  wire logic                  timerOverflow,
    output logic                       aluClkEn,
    output logic                       oscEn,
    output logic                       wakeVector,
    output logic                       fetchRestart,
    output logic                       cpuIntIbf,
    output logic                       cpuIntTimer,
    // system outputs
    output logic                       kbd_irq_out,
    output logic                       aux_irq_out,
    output logic                       a20_gate_out,
    // port1 bits 7,6,2 pins
    output logic [2:0]                 port1PinOut,
    output logic [2:0]                 port1PinOe,
    // open-drain keyboard/mouse pins, order kbclk, kbdat, mclk, mouse_data_pin
    input  wire logic [3:0]            kmPinIn,
    output logic [3:0]                 kmPinOut,
    output logic [3:0]                 kmPinOe,
    output logic                       test_input_zero,
    output logic                       test_input_one,
    output logic                       port1_bit0,
    output logic                       port1_bit1
);
    // ==========================================================
    // state
    byte_t      outData_r;
    byte_t      status_r;
    byte_t      statusView;
    logic       flagsEn_r;
    pwr_state_t pwr_r;
    logic       wakeVector_r;
    logic       fetchRestart_r;
    logic       hostWrite;
    logic       hostDataRead;
    logic       fifoOutValid;
    byte_t      fifoOutData;
    logic [2:0] pinSet_r;
    logic [4:0] holdCnt_r [3];

    assign hostWrite    = clkEn && hostWr && hostWrReady
                          && (hostAddr == `KBC_ADDR_DATA || hostAddr == `KBC_ADDR_CMD);
    assign hostDataRead = clkEn && hostRd && (hostAddr == `KBC_ADDR_DATA);

    // ==========================================================
    // input path: host bytes queue for the cpu; host stalls when full
    kbc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_in_fifo (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .clkEn    (clkEn),
        .inData   (hostWrData),
        .inValid  (hostWrite),
        .inReady  (hostWrReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (cpuDataRd)
    );
    assign cpuRdData  = fifoOutData;
    assign cpuInValid = fifoOutValid;

    // ==========================================================
    // host read mux, purely combinational so status read has no effect
    always_comb begin
        if (hostAddr == `KBC_ADDR_CMD) begin
            hostRdData = statusView;
        end else if (hostAddr == `KBC_ADDR_DATA) begin
            hostRdData = outData_r;
        end else begin
            hostRdData = 8'h00;
        end
    end

    // output data register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            outData_r <= 8'h00;
        end else if (clkEn && cpuDataWr) begin
            outData_r <= cpuWrData;
        end
    end

    // gating enable latched once firmware asks for it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flagsEn_r <= 1'b0;
        end else if (clkEn && cpuEnFlags) begin
            flagsEn_r <= 1'b1;
        end
    end

    // ==========================================================
    // status register; sets win over clears in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            status_r <= `KBC_ST_RESET;
        end else if (clkEn) begin
            if (cpuStatusWr) begin
                status_r <= (status_r & ~`KBC_ST_UD_MASK)
                            | (cpuWrData & `KBC_ST_UD_MASK);
            end
            if (cpuDataWr) begin
                status_r[`KBC_ST_OBF_POS] <= 1'b1;
            end else if (hostDataRead && flagsEn_r) begin
                status_r[`KBC_ST_OBF_POS] <= 1'b0;
            end
            if (hostWrite) begin
                status_r[`KBC_ST_CD_POS] <= hostAddr[2];
            end
        end
    end

    // input-full is the fifo occupancy itself, so it never lags a push or a pop
    always_comb begin
        statusView                  = status_r;
        statusView[`KBC_ST_IBF_POS] = fifoOutValid;
    end

    // ==========================================================
    // interrupt outputs
    always_comb begin
        if (flagsEn_r) begin
            kbd_irq_out = port2Out[4] & status_r[`KBC_ST_OBF_POS];
            aux_irq_out = port2Out[5] & ~statusView[`KBC_ST_IBF_POS];
        end else begin
            kbd_irq_out = port2Out[4];
            aux_irq_out = port2Out[5];
        end
    end
    assign a20_gate_out = port2Out[1];

    // only these two reach the embedded core
    assign cpuIntIbf   = ibfIntEnable & statusView[`KBC_ST_IBF_POS];
    assign cpuIntTimer = timerOverflow;

    // ==========================================================
    // port1 pins: one pulse stretcher per pin; no input/invert path exists
    localparam int P1_IDX [3] = '{7, 6, 2};
    for (genvar i = 0; i < 3; i++) begin : g_p1pin
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                pinSet_r[i]  <= 1'b0;
                holdCnt_r[i] <= 5'h00;
            end else if (clkEn) begin
                pinSet_r[i] <= port1Out[P1_IDX[i]];
                if (port1Out[P1_IDX[i]] && !pinSet_r[i] && !port1OpenDrain) begin
                    holdCnt_r[i] <= 5'(HOLD_CYC);
                end else if (!port1Out[P1_IDX[i]] || port1OpenDrain) begin
                    holdCnt_r[i] <= 5'h00;
                end else if (holdCnt_r[i] != 5'h00) begin
                    holdCnt_r[i] <= holdCnt_r[i] - 5'h01;
                end
            end
        end
        // drive low for 0; in push-pull a fresh 1 drives high at once, before the stretcher
        // has seen it, so the pin never floats between the low and the pulse
        assign port1PinOut[i] = port1Out[P1_IDX[i]];
        assign port1PinOe[i]  = !port1Out[P1_IDX[i]]
                                || (!port1OpenDrain
                                    && (holdCnt_r[i] != 5'h00 || !pinSet_r[i]));
    end

    // ==========================================================
    // keyboard/mouse open-drain pins: a port bit of 1 pulls the pin low
    assign kmPinOut        = 4'h0;
    assign kmPinOe         = {port2Out[6], port2Out[7], port2Out[3], port2Out[2]};
    assign test_input_zero = kmPinIn[3];
    assign port1_bit0      = kmPinIn[2];
    assign test_input_one  = kmPinIn[1];
    assign port1_bit1      = kmPinIn[0];

    // ==========================================================
    // powerdown; a host byte wakes either mode, reset restarts at 0
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pwr_r          <= PWR_RUN;
            wakeVector_r   <= 1'b0;
            fetchRestart_r <= 1'b1;
        end else if (clkEn) begin
            fetchRestart_r <= 1'b0;
            wakeVector_r   <= 1'b0;
            unique case (pwr_r)
                PWR_RUN: begin
                    if (cpuStop) begin
                        pwr_r <= PWR_HARD;
                    end else if (cpuHalt) begin
                        pwr_r <= PWR_SOFT;
                    end
                end
                PWR_SOFT, PWR_HARD: begin
                    if (hostWrite) begin
                        pwr_r        <= PWR_RUN;
                        wakeVector_r <= ibfIntEnable;
                    end
                end
                default: pwr_r <= PWR_RUN;
            endcase
        end
    end
    assign aluClkEn     = (pwr_r == PWR_RUN);
    assign oscEn        = (pwr_r != PWR_HARD);
    assign wakeVector   = wakeVector_r;
    assign fetchRestart = fetchRestart_r;

    // ==========================================================
    // checks
    property p_obfSet;
        @(posedge clk_sys) disable iff (!resetn)
        (clkEn && cpuDataWr) |=> status_r[`KBC_ST_OBF_POS];
    endproperty
    a_obfSet: assert property (p_obfSet) else $error("output-full not set");

    property p_cdBit;
        @(posedge clk_sys) disable iff (!resetn)
        hostWrite |=> status_r[`KBC_ST_CD_POS] == $past(hostAddr[2]);
    endproperty
    a_cdBit: assert property (p_cdBit) else $error("command bit wrong");

    property p_ibfSet;
        @(posedge clk_sys) disable iff (!resetn)
        hostWrite |=> statusView[`KBC_ST_IBF_POS];
    endproperty
    a_ibfSet: assert property (p_ibfSet) else $error("input-full not set");

    property p_obfClr;
        @(posedge clk_sys) disable iff (!resetn)
        (hostDataRead && flagsEn_r && !cpuDataWr) |=> !kbd_irq_out;
    endproperty
    a_obfClr: assert property (p_obfClr) else $error("irq not cleared");

    property p_kbdGate;
        @(posedge clk_sys) disable iff (!resetn)
        !port2Out[4] |-> !kbd_irq_out;
    endproperty
    a_kbdGate: assert property (p_kbdGate) else $error("kbd irq not forced low");

    property p_auxFollow;
        @(posedge clk_sys) disable iff (!resetn)
        !flagsEn_r |-> aux_irq_out == port2Out[5];
    endproperty
    a_auxFollow: assert property (p_auxFollow) else $error("aux irq mismatch");

    property p_statusRead;
        @(posedge clk_sys) disable iff (!resetn)
        (clkEn && hostRd && hostAddr == `KBC_ADDR_CMD && !cpuDataWr && !cpuDataRd
         && !hostWrite && !cpuStatusWr) |=> $stable(status_r);
    endproperty
    a_statusRead: assert property (p_statusRead) else $error("status read side effect");

    property p_kmPins;
        @(posedge clk_sys) disable iff (!resetn)
        port2Out[6] |-> kmPinOe[3] && !kmPinOut[3];
    endproperty
    a_kmPins: assert property (p_kmPins) else $error("kb clock pin not low");

    property p_kbdFollow;
        @(posedge clk_sys) disable iff (!resetn)
        !flagsEn_r |-> kbd_irq_out == port2Out[4];
    endproperty
    a_kbdFollow: assert property (p_kbdFollow) else $error("kbd irq not following");

    property p_auxGate;
        @(posedge clk_sys) disable iff (!resetn)
        (flagsEn_r && port2Out[5]) |-> aux_irq_out == !statusView[`KBC_ST_IBF_POS];
    endproperty
    a_auxGate: assert property (p_auxGate) else $error("aux irq not inverse full");

    property p_odRelease;
        @(posedge clk_sys) disable iff (!resetn)
        port1OpenDrain |-> port1PinOe == ~{port1Out[7], port1Out[6], port1Out[2]};
    endproperty
    a_odRelease: assert property (p_odRelease) else $error("open-drain pin driven");

    property p_wakeRun;
        @(posedge clk_sys) disable iff (!resetn)
        (pwr_r != PWR_RUN && hostWrite) |=> aluClkEn && oscEn;
    endproperty
    a_wakeRun: assert property (p_wakeRun) else $error("host byte did not wake");

    property p_outData;
        @(posedge clk_sys) disable iff (!resetn)
        (clkEn && cpuDataWr) |=> outData_r == $past(cpuWrData);
    endproperty
    a_outData: assert property (p_outData) else $error("output byte not loaded");

    property p_stopOsc;
        @(posedge clk_sys) disable iff (!resetn)
        (clkEn && aluClkEn && cpuStop) |=> !oscEn;
    endproperty
    a_stopOsc: assert property (p_stopOsc) else $error("oscillator not stopped");
endmodule : kbc_host_mailbox_port

// ===== kbc_host_mailbox_port_bench.sv
// self-checking bench for the keyboard-controller host mailbox
`timescale 1ns/1ps
module kbc_host_mailbox_port_bench;
    import kbc_mailbox_pkg::*;
    localparam int HOLD = 3;
    logic clk_sys = 1'b0;
    logic resetn, clkEn, cpuDataWr, cpuDataRd, cpuStatusWr, cpuEnFlags, port1OpenDrain;
    logic cpuHalt, cpuStop, ibfIntEnable, timerOverflow, hostWr, hostRd, hostWrReady;
    logic cpuInValid, aluClkEn, oscEn, wakeVector, fetchRestart, cpuIntIbf, cpuIntTimer;
    logic kbd_irq_out, aux_irq_out, a20_gate_out, test_input_zero, test_input_one;
    logic port1_bit0, port1_bit1;
    logic [7:0] hostAddr;
    logic [2:0] port1PinOut, port1PinOe;
    logic [3:0] kmPinIn, kmPinOut, kmPinOe;
    byte_t cpuWrData, port1Out, port2Out, cpuRdData, hostRdData, hostWrData;
    int errors = 0;
    int checked = 0;
    // reference model of the mailbox
    byte_t inQ[$];
    byte_t userRef, outRef;
    logic cdRef, obfRef;

    always #12.5 clk_sys = ~clk_sys;

    kbc_host_mailbox_port #(.HOLD_CYC(HOLD), .FIFO_DEPTH(4)) i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn), .hostAddr(hostAddr),
        .hostWr(hostWr), .hostRd(hostRd), .hostWrData(hostWrData),
        .hostRdData(hostRdData), .hostWrReady(hostWrReady), .cpuDataWr(cpuDataWr),
        .cpuWrData(cpuWrData), .cpuDataRd(cpuDataRd), .cpuRdData(cpuRdData),
        .cpuInValid(cpuInValid), .cpuStatusWr(cpuStatusWr), .cpuEnFlags(cpuEnFlags),
        .port1Out(port1Out), .port2Out(port2Out), .port1OpenDrain(port1OpenDrain),
        .cpuHalt(cpuHalt), .cpuStop(cpuStop), .ibfIntEnable(ibfIntEnable),
        .timerOverflow(timerOverflow), .aluClkEn(aluClkEn), .oscEn(oscEn),
        .wakeVector(wakeVector), .fetchRestart(fetchRestart), .cpuIntIbf(cpuIntIbf),
        .cpuIntTimer(cpuIntTimer), .kbd_irq_out(kbd_irq_out), .aux_irq_out(aux_irq_out),
        .a20_gate_out(a20_gate_out), .port1PinOut(port1PinOut), .port1PinOe(port1PinOe),
        .kmPinIn(kmPinIn), .kmPinOut(kmPinOut), .kmPinOe(kmPinOe),
        .test_input_zero(test_input_zero), .test_input_one(test_input_one),
        .port1_bit0(port1_bit0), .port1_bit1(port1_bit1));

    kbc_host_model i_host (.clk_sys(clk_sys), .hostWrReady(hostWrReady),
        .hostRdData(hostRdData), .hostAddr(hostAddr), .hostWr(hostWr),
        .hostRd(hostRd), .hostWrData(hostWrData));

    // ==========================================
    // comparison, status read, cpu strobes, fifo drain
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic stat();
        byte_t s;
        i_host.read(8'h64, s);
        chk("status", (userRef & 8'hf4) | {4'h0, cdRef, 2'b00, obfRef}
            | {6'h00, inQ.size() != 0, 1'b0}, s);
    endtask : stat

    // k: 0 data write, 1 status write, 2 flags on, 3 halt, 4 stop, 5 data pop
    task automatic pulse(input int k);
        @(negedge clk_sys);
        {cpuDataRd, cpuStop, cpuHalt, cpuEnFlags, cpuStatusWr, cpuDataWr} = 6'h01 << k;
        @(negedge clk_sys);
        {cpuDataRd, cpuStop, cpuHalt, cpuEnFlags, cpuStatusWr, cpuDataWr} = 6'h00;
    endtask : pulse

    task automatic drain();
        while (inQ.size() != 0) begin
            @(negedge clk_sys);
            chk("cpu byte", inQ[0], cpuRdData);
            chk("in valid", 8'h01, {7'h0, cpuInValid});
            pulse(5);
            void'(inQ.pop_front());
            stat();
        end
    endtask : drain

    task automatic give_verdict();
        $display("comparisons %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    // watchdog well beyond the expected run
    initial begin
        #(25 * 20000);
        errors++;
        give_verdict();
    end

    // ==========================================
    // main sequence
    initial begin
        byte_t d;
        bit tk;
        int n;
        {cpuDataRd, cpuStop, cpuHalt, cpuEnFlags, cpuStatusWr, cpuDataWr} = 6'h00;
        {resetn, port1OpenDrain, ibfIntEnable, timerOverflow} = 4'h0;
        {cpuWrData, port1Out, port2Out} = 24'h0;
        {clkEn, kmPinIn, userRef, cdRef, obfRef} = 15'h4000;
        void'($urandom(35985));
        repeat (6) @(negedge clk_sys);
        resetn = 1'b1;
        chk("kbd irq", 8'h00, {7'h0, kbd_irq_out});
        stat();
        // data and command writes fill the fifo, a fifth is refused
        for (int i = 0; i < 5; i++) begin
            d = byte_t'($urandom);
            i_host.write(i[0] ? 8'h64 : 8'h60, d, (i < 4) ? 4 : 0, tk);
            chk("taken", {7'h0, inQ.size() < 4}, {7'h0, tk});
            if (inQ.size() < 4) begin
                inQ.push_back(d);
                cdRef = i[0];
            end
            stat();
        end
        chk("wr ready", 8'h00, {7'h0, hostWrReady});
        drain();
        i_host.write(8'h61, 8'ha5, 0, tk);
        stat();
        // port2 drives irqs directly while gating is off; pin mapping
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            port2Out = byte_t'($urandom);
            kmPinIn = 4'($urandom);
            #1;
            chk("kbd irq", {7'h0, port2Out[4]}, {7'h0, kbd_irq_out});
            chk("aux irq", {7'h0, port2Out[5]}, {7'h0, aux_irq_out});
            chk("a20", {7'h0, port2Out[1]}, {7'h0, a20_gate_out});
            chk("km oe", {4'h0, port2Out[6], port2Out[7], port2Out[3], port2Out[2]},
                {4'h0, kmPinOe});
            chk("km fb", {4'h0, kmPinIn}, {4'h0, test_input_zero, port1_bit0,
                test_input_one, port1_bit1});
            chk("km out", 8'h00, {4'h0, kmPinOut});
        end
        cpuWrData = 8'hff;
        pulse(1);
        userRef = 8'hff;
        stat();
        // gating on: output byte raises kbd irq, host read clears it
        port2Out = 8'h30;
        ibfIntEnable = 1'b1;
        pulse(2);
        cpuWrData = byte_t'($urandom);
        outRef = cpuWrData;
        pulse(0);
        obfRef = 1'b1;
        stat();
        chk("kbd irq", 8'h01, {7'h0, kbd_irq_out});
        chk("aux irq", 8'h01, {7'h0, aux_irq_out});
        port2Out = 8'h20;
        #1;
        chk("kbd irq", 8'h00, {7'h0, kbd_irq_out});
        port2Out = 8'h30;
        cpuHalt = 1'b0;
        pulse(3);
        chk("alu clk", 8'h00, {7'h0, aluClkEn});
        i_host.write(8'h60, 8'h5a, 4, tk);
        chk("wake", 8'h01, {7'h0, wakeVector});
        inQ.push_back(8'h5a);
        cdRef = 1'b0;
        chk("alu clk", 8'h01, {7'h0, aluClkEn});
        chk("aux irq", 8'h00, {7'h0, aux_irq_out});
        chk("ibf int", 8'h01, {7'h0, cpuIntIbf});
        i_host.read(8'h60, d);
        chk("out byte", outRef, d);
        obfRef = 1'b0;
        chk("kbd irq", 8'h00, {7'h0, kbd_irq_out});
        stat();
        drain();
        pulse(4);
        chk("osc", 8'h00, {7'h0, oscEn});
        i_host.write(8'h64, 8'h3c, 4, tk);
        inQ.push_back(8'h3c);
        cdRef = 1'b1;
        chk("osc", 8'h01, {7'h0, oscEn});
        drain();
        timerOverflow = 1'b1;
        #1;
        chk("timer int", 8'h01, {7'h0, cpuIntTimer});
        // push-pull pulse then release; open-drain never drives high
        for (int od = 0; od < 2; od++) begin
            @(negedge clk_sys);
            port1OpenDrain = od[0];
            port1Out = 8'h00;
            @(negedge clk_sys);
            chk("p1 low", 8'h07, {2'b00, port1PinOut, port1PinOe});
            port1Out = 8'hc4;
            n = 0;
            repeat (HOLD + 4) begin
                @(negedge clk_sys);
                n += (port1PinOe == 3'b111);
            end
            chk("p1 hold", (od == 0) ? 8'h01 : 8'h00,
                {7'h0, n >= HOLD && n <= HOLD + 1});
            chk("p1 rel", 8'h00, {5'h0, port1PinOe});
        end
        // reset out of halt restarts fetch and clears the mailbox
        pulse(3);
        resetn = 1'b0;
        #1;
        chk("restart", 8'h01, {7'h0, fetchRestart});
        repeat (6) @(negedge clk_sys);
        resetn = 1'b1;
        {userRef, cdRef} = 9'h0;
        @(negedge clk_sys);
        chk("alu clk", 8'h01, {7'h0, aluClkEn});
        stat();
        // frozen clock enable: an output byte write must not land
        clkEn = 1'b0;
        cpuWrData = 8'h81;
        pulse(0);
        stat();
        give_verdict();
    end
endmodule : kbc_host_mailbox_port_bench

// ===== kbc_host_model.sv
// host-side partner issuing i/o writes and reads on the mailbox port
`timescale 1ns/1ps
module kbc_host_model
    import kbc_mailbox_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   hostWrReady,
    input  wire kbc_mailbox_pkg::byte_t hostRdData,
    output logic [7:0]                  hostAddr,
    output logic                        hostWr,
    output logic                        hostRd,
    output kbc_mailbox_pkg::byte_t      hostWrData
);
    // ==========================================
    // idle bus
    initial begin
        hostAddr = 8'h00;
        hostWr = 1'b0;
        hostRd = 1'b0;
        hostWrData = 8'h00;
    end

    // ==========================================
    // write: waits up to maxWait cycles for room, then gives up
    // released lines show the inverse so stale values never look valid
    task automatic write(input logic [7:0] a, input byte_t d, input int maxWait,
                         output bit taken);
        int n;
        n = 0;
        @(negedge clk_sys);
        hostAddr = a;
        hostWrData = d;
        hostWr = 1'b1;
        #1;
        while (hostWrReady !== 1'b1 && n < maxWait) begin
            @(negedge clk_sys);
            #1;
            n++;
        end
        taken = (hostWrReady === 1'b1);
        @(negedge clk_sys);
        hostWr = 1'b0;
        hostAddr = ~a;
        hostWrData = ~d;
    endtask : write

    // ==========================================
    // read: one cycle of strobe, data is combinational
    task automatic read(input logic [7:0] a, output byte_t d);
        @(negedge clk_sys);
        hostAddr = a;
        hostRd = 1'b1;
        #1;
        d = hostRdData;
        @(negedge clk_sys);
        hostRd = 1'b0;
        hostAddr = ~a;
    endtask : read
endmodule : kbc_host_model

// ===== kbc_mailbox_params.svh
// constants for the keyboard-controller host mailbox
`ifndef KBC_MAILBOX_PARAMS_SVH
`define KBC_MAILBOX_PARAMS_SVH
`define KBC_ADDR_DATA      8'h60
`define KBC_ADDR_CMD       8'h64
`define KBC_ST_OBF_POS     0
`define KBC_ST_IBF_POS     1
`define KBC_ST_CD_POS      3
`define KBC_ST_RESET       8'h00
`define KBC_ST_UD_MASK     8'hf4
`define KBC_CLK_NS         25
`define KBC_HOLD_NS        500
`define KBC_HOLD_CYC       ((`KBC_HOLD_NS + `KBC_CLK_NS - 1) / `KBC_CLK_NS)
`define KBC_FIFO_DEPTH     4
`endif

// ===== kbc_mailbox_pkg.sv
// types for the keyboard-controller host mailbox
package kbc_mailbox_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        PWR_RUN  = 2'b00,
        PWR_SOFT = 2'b01,
        PWR_HARD = 2'b11
    } pwr_state_t;
endpackage : kbc_mailbox_pkg
